/* psc_pkg.sv */
// Purpose: constants and types for the power start-clear and run control
// Assumes: 20 MHz system clock, AXI4-Lite register access
// Notes: Operation list below, one line per item
// Operation
// - power delay ready holds about one second
// - delay ready holds run latch in initialize
// - two run states; panel works only initialize
// - run inhibited until start switch used
// - bad power while stopped blocks the clock
// - bad power, no power interrupt: request reset
// - run reset only at done pulse six
// - start clear at turn-on and start
// - start/manual pulse one clear steal, interrupt
// - start clear clears power interrupt latch
// - start clear resets double period registers
// - start clear zeroes instruction register
// - start clear clears flags, pulser, priority
// - instruction clear from start or done-seven
// - instruction clear selects j, clears latches
// - instruction clear resets multiply, divide latches
// - switch register drives the utility gates
// - panel request from load/examine in initialize
// - start press and release sets run
// - stop ends run after current cycle
// - running ignores next/load panel switches
package psc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int POWER_DELAY_MS = 1000;
  localparam int POWER_DELAY_CYC = (CLK_HZ / 1000) * POWER_DELAY_MS;
  localparam int HALT_NS = 1000;
  localparam int HALT_CYC = HALT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int WORD_W = 12;
  localparam int PULSE_N = 8;
  localparam int ADDR_W = 5;
  localparam int SYNC_W = 18;
  localparam logic [PULSE_N-1:0] TP_FIRST = 8'h01;
  localparam int TP_MANUAL_CLR = 1;
  localparam int TP_RUN_CLR = 6;
  localparam int TP_LAST = 7;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] REG_LATCH = 5'h08;
  localparam logic [ADDR_W-1:0] REG_INSTR = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_SWITCH = 5'h10;
  localparam int CTRL_PWR_INT = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_STEAL = 2;
  localparam int CTRL_IRQ = 3;
  localparam int CTRL_J_CLR = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic {PSC_INIT, PSC_RUN} psc_run_e;

  typedef struct packed {
    logic start_double;
    logic double_period;
    logic flag;
    logic execute_phase;
    logic indirect;
    logic overflow;
    logic priority_enable;
    logic interrupt_enable;
    logic first_last_memory;
    logic first_last_location;
    logic execute_latch;
    logic indirect_cycle;
    logic indirect_memory;
    logic multiply_bit;
    logic divide_wait;
    logic divide_once;
  } psc_latch_s;

  typedef struct packed {
    logic clock_block;
    logic run_reset_request;
    logic power_interrupt;
    logic interrupt_request;
    logic cycle_steal_request;
    logic bad_power;
    logic power_delay_ready;
    logic run;
    logic j_transfer_select;
  } psc_status_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic load_address;
    logic load_memory;
    logic examine;
  } psc_panel_s;

  localparam psc_latch_s LATCH_RST = '0;
endpackage

/* psc_core.sv */
// Purpose: power-up start clear, run/initialize latch and manual pulser
// Assumes: panel switches high while pressed, bad power high when low supply
// Notes: registers over AXI4-Lite; clears win over software writes
`timescale 1ns/1ps
`default_nettype none
module psc_core #(
  parameter int POWER_DELAY = psc_pkg::POWER_DELAY_CYC
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic bad_power_in,
  input wire psc_pkg::psc_panel_s panel_in,
  input wire logic [psc_pkg::WORD_W-1:0] switch_reg_in,
  input wire logic done_in,
  input wire logic pulse_generation_enable_in,
  input wire logic s_axi_awvalid_in,
  input wire logic [psc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic [psc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_rready_in,
  output logic s_axi_awready_out,
  output logic s_axi_wready_out,
  output logic s_axi_bvalid_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_arready_out,
  output logic s_axi_rvalid_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic run_out,
  output logic power_delay_ready_out,
  output logic start_clear_out,
  output logic instruction_level_clear_out,
  output logic manual_panel_request_out,
  output logic clock_block_out,
  output logic [psc_pkg::PULSE_N-1:0] timing_pulse_out,
  output logic [psc_pkg::WORD_W-1:0] utility_gates_out
);
  import psc_pkg::*;

  localparam int DLY_W = $clog2(POWER_DELAY + 1);

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  psc_panel_s pan;
  psc_panel_s pan_d;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      pan_d <= '0;
    end else begin
      sync1 <= {switch_reg_in, panel_in, bad_power_in};
      sync2 <= sync1;
      pan_d <= sync2[5:1];
    end
  end

  logic bad_pwr;
  assign bad_pwr = sync2[0];
  assign pan = sync2[5:1];

  // start acts on release, as the operator lets go of the switch
  logic start_evt;
  logic stop_evt;
  logic manual_evt;
  assign start_evt = pan_d.start && !pan.start;
  assign stop_evt = pan.stop && !pan_d.stop;
  assign manual_evt = (pan.load_address && !pan_d.load_address)
      || (pan.load_memory && !pan_d.load_memory)
      || (pan.examine && !pan_d.examine);

  // ----------------------------------------------------------------
  // power delay
  // ----------------------------------------------------------------
  logic [DLY_W-1:0] dly_cnt;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_cnt <= DLY_W'(POWER_DELAY);
      power_delay_ready_out <= 1'b1;
    end else if (dly_cnt != '0) begin
      dly_cnt <= dly_cnt - 1'b1;
    end else begin
      power_delay_ready_out <= 1'b0;
    end
  end
  a_delay_hold: assert property (power_delay_ready_out && dly_cnt != '0
      |=> power_delay_ready_out) else $error("delay ready dropped early");

  // ----------------------------------------------------------------
  // bus side control bits
  // ----------------------------------------------------------------
  logic wr_go;
  logic rd_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] ctrl_wr;
  assign wr_go = s_axi_awready_out && s_axi_awvalid_in;
  assign rd_go = s_axi_arready_out && s_axi_arvalid_in;
  assign wr_addr = s_axi_awaddr_in;
  assign ctrl_wr = (wr_go && wr_addr == REG_CTRL)
      ? merge(WORD_ZERO, s_axi_wdata_in, s_axi_wstrb_in) : WORD_ZERO;

  // ----------------------------------------------------------------
  // run latch
  // ----------------------------------------------------------------
  psc_run_e run_q;
  logic run_reset_request;
  logic power_interrupt;
  logic stop_pend;
  logic run_clear_strobe;
  logic manual_cycle;
  assign run_clear_strobe = pulse_generation_enable_in && done_in
      && timing_pulse_out[TP_RUN_CLR] && run_q == PSC_RUN;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q <= PSC_INIT;
    end else begin
      case (run_q)
        PSC_INIT: begin
          // panel work never reaches run; only start does
          if (!power_delay_ready_out && start_evt) begin
            run_q <= PSC_RUN;
          end
        end
        PSC_RUN: begin
          if (power_delay_ready_out) begin
            run_q <= PSC_INIT;
          end else if (run_clear_strobe && (run_reset_request || stop_pend)) begin
            run_q <= PSC_INIT;
          end
        end
        default: run_q <= PSC_INIT;
      endcase
    end
  end
  a_init_hold: assert property (power_delay_ready_out
      |=> run_q == PSC_INIT) else $error("run while delay ready");
  a_run_keep: assert property (run_q == PSC_RUN && !run_clear_strobe
      && !power_delay_ready_out |=> run_q == PSC_RUN)
      else $error("run cleared off pulse six");

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_out <= 1'b0;
    end else begin
      run_out <= (run_q == PSC_RUN);
    end
  end

  // set wins over the clear that applies it
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_reset_request <= 1'b0;
    end else if (bad_pwr && !power_interrupt) begin
      run_reset_request <= 1'b1;
    end else if (run_clear_strobe) begin
      run_reset_request <= 1'b0;
    end
  end
  a_reset_req: assert property (bad_pwr && !power_interrupt
      |=> run_reset_request) else $error("run reset request missed");

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stop_pend <= 1'b0;
    end else if (stop_evt || ctrl_wr[CTRL_STOP]) begin
      stop_pend <= 1'b1;
    end else if (run_q == PSC_INIT) begin
      stop_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_interrupt <= 1'b0;
    end else if (start_clear_out) begin
      power_interrupt <= 1'b0;
    end else if (ctrl_wr[CTRL_PWR_INT]) begin
      power_interrupt <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // clock block and clear strobes
  // ----------------------------------------------------------------
  // three cycles from the pin, well inside the halt window
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clock_block_out <= 1'b0;
    end else begin
      clock_block_out <= bad_pwr && run_q == PSC_INIT;
    end
  end
  a_clock_block: assert property (bad_pwr && run_q == PSC_INIT
      |=> clock_block_out) else $error("clock not blocked");

  logic next_start_clear;
  assign next_start_clear = power_delay_ready_out
      || (start_evt && run_q == PSC_INIT);
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      start_clear_out <= 1'b1;
      instruction_level_clear_out <= 1'b1;
    end else begin
      start_clear_out <= next_start_clear;
      instruction_level_clear_out <= next_start_clear
          || (done_in && timing_pulse_out[TP_LAST]);
    end
  end
  a_start_clear: assert property (start_clear_out |-> $past(power_delay_ready_out)
      || ($past(start_evt) && $past(run_q) == PSC_INIT))
      else $error("stray start clear");
  a_instr_clear: assert property (done_in && timing_pulse_out[TP_LAST]
      |=> instruction_level_clear_out) else $error("no instruction clear");

  // ----------------------------------------------------------------
  // panel requests and timing pulser
  // ----------------------------------------------------------------
  logic next_manual;
  assign next_manual = manual_evt && run_q == PSC_INIT
      && !power_delay_ready_out;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      manual_panel_request_out <= 1'b0;
    end else begin
      manual_panel_request_out <= next_manual;
    end
  end
  a_panel_run: assert property (run_q == PSC_RUN
      |=> !manual_panel_request_out) else $error("panel request in run");

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      manual_cycle <= 1'b0;
    end else if (start_clear_out || timing_pulse_out[TP_LAST]) begin
      manual_cycle <= 1'b0;
    end else if (manual_panel_request_out) begin
      manual_cycle <= 1'b1;
    end
  end

  // initialize gives a single string of pulses, run recycles
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timing_pulse_out <= '0;
    end else if (start_clear_out || clock_block_out) begin
      timing_pulse_out <= '0;
    end else if (timing_pulse_out[TP_LAST]) begin
      timing_pulse_out <= (run_q == PSC_RUN) ? TP_FIRST : '0;
    end else if (timing_pulse_out != '0) begin
      timing_pulse_out <= timing_pulse_out << 1;
    end else if (run_q == PSC_RUN || manual_panel_request_out) begin
      timing_pulse_out <= TP_FIRST;
    end
  end

  logic manual_cycle_clear;
  assign manual_cycle_clear = start_clear_out
      || (manual_cycle && timing_pulse_out[TP_MANUAL_CLR]);

  // ----------------------------------------------------------------
  // cleared processor state
  // ----------------------------------------------------------------
  logic cycle_steal_request;
  logic interrupt_request_reg;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cycle_steal_request <= 1'b0;
      interrupt_request_reg <= 1'b0;
    end else if (manual_cycle_clear) begin
      cycle_steal_request <= 1'b0;
      interrupt_request_reg <= 1'b0;
    end else begin
      cycle_steal_request <= cycle_steal_request || ctrl_wr[CTRL_STEAL];
      interrupt_request_reg <= interrupt_request_reg || ctrl_wr[CTRL_IRQ];
    end
  end
  a_steal_clr: assert property (manual_cycle_clear
      |=> !cycle_steal_request && !interrupt_request_reg)
      else $error("request regs not cleared");

  psc_latch_s lat;
  psc_latch_s lat_wr;
  logic [WORD_W-1:0] instr_reg;
  logic j_transfer_select;
  // only the low half word holds latches; upper byte lanes fall away
  assign lat_wr = psc_latch_s'(16'(merge({16'h0000, lat}, s_axi_wdata_in,
      s_axi_wstrb_in)));

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lat <= LATCH_RST;
    end else begin
      if (wr_go && wr_addr == REG_LATCH) begin
        lat <= lat_wr;
      end
      if (instruction_level_clear_out) begin
        lat.first_last_memory <= 1'b0;
        lat.first_last_location <= 1'b0;
        lat.execute_latch <= 1'b0;
        lat.indirect_cycle <= 1'b0;
        lat.indirect_memory <= 1'b0;
        lat.multiply_bit <= 1'b0;
        lat.divide_wait <= 1'b0;
        lat.divide_once <= 1'b0;
      end
      if (start_clear_out) begin
        lat.start_double <= 1'b0;
        lat.double_period <= 1'b0;
        lat.flag <= 1'b0;
        lat.execute_phase <= 1'b0;
        lat.indirect <= 1'b0;
        lat.overflow <= 1'b0;
        lat.priority_enable <= 1'b0;
        lat.interrupt_enable <= 1'b0;
      end
    end
  end
  a_start_lat: assert property (start_clear_out |=> lat == LATCH_RST
      && instr_reg == '0) else $error("start clear left state");

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      instr_reg <= '0;
    end else if (start_clear_out) begin
      instr_reg <= '0;
    end else if (wr_go && wr_addr == REG_INSTR) begin
      instr_reg <= WORD_W'(merge({20'h00000, instr_reg}, s_axi_wdata_in,
          s_axi_wstrb_in));
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      j_transfer_select <= 1'b0;
    end else if (instruction_level_clear_out) begin
      j_transfer_select <= 1'b1;
    end else if (ctrl_wr[CTRL_J_CLR]) begin
      j_transfer_select <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      utility_gates_out <= '0;
    end else begin
      utility_gates_out <= sync2[SYNC_W-1:6];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // address and data are taken together, so either arrival order works
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else begin
      s_axi_awready_out <= !s_axi_awready_out && !s_axi_bvalid_out
          && s_axi_awvalid_in && s_axi_wvalid_in;
      s_axi_wready_out <= !s_axi_awready_out && !s_axi_bvalid_out
          && s_axi_awvalid_in && s_axi_wvalid_in;
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        if (wr_addr == REG_CTRL || wr_addr == REG_LATCH
            || wr_addr == REG_INSTR) begin
          s_axi_bresp_out <= RESP_OKAY;
        end else begin
          s_axi_bresp_out <= RESP_SLVERR;
        end
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  psc_status_s stat;
  assign stat = '{clock_block: clock_block_out,
      run_reset_request: run_reset_request, power_interrupt: power_interrupt,
      interrupt_request: interrupt_request_reg,
      cycle_steal_request: cycle_steal_request, bad_power: bad_pwr,
      power_delay_ready: power_delay_ready_out, run: run_q == PSC_RUN,
      j_transfer_select: j_transfer_select};

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= WORD_ZERO;
      s_axi_rresp_out <= RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out
          && s_axi_arvalid_in;
      if (rd_go) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= RESP_OKAY;
        if (s_axi_araddr_in == REG_CTRL) begin
          s_axi_rdata_out <= {28'h0000000, power_interrupt, 3'h0};
        end else if (s_axi_araddr_in == REG_STATUS) begin
          s_axi_rdata_out <= {23'h000000, stat};
        end else if (s_axi_araddr_in == REG_LATCH) begin
          s_axi_rdata_out <= {16'h0000, lat};
        end else if (s_axi_araddr_in == REG_INSTR) begin
          s_axi_rdata_out <= {20'h00000, instr_reg};
        end else if (s_axi_araddr_in == REG_SWITCH) begin
          s_axi_rdata_out <= {20'h00000, utility_gates_out};
        end else begin
          s_axi_rdata_out <= WORD_ZERO;
          s_axi_rresp_out <= RESP_SLVERR;
        end
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* psc_panel_model.sv */
// Purpose: operator panel switches and supply sense for the run control
// Assumes: a switch reads high while pressed, bad power high on low supply
// Notes: pins change just after a clock edge and hold long enough to sync
`timescale 1ns/1ps
`default_nettype none
module psc_panel_model (
  input wire logic clk_in,
  output logic bad_power_out,
  output psc_pkg::psc_panel_s panel_out,
  output logic [psc_pkg::WORD_W-1:0] switch_reg_out
);
  import psc_pkg::*;
  logic [4:0] pins = 5'h00;
  assign panel_out = psc_panel_s'(pins);
  initial begin
    bad_power_out = 1'b0;
    switch_reg_out = 12'h000;
  end
  // press and release; the block acts on the release of start, on the press of the others
  task press(input int k);
    @(posedge clk_in) pins[k] <= 1'b1;
    repeat (6) @(posedge clk_in);
    pins[k] <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  task set_bad(input logic v);
    @(posedge clk_in) bad_power_out <= v;
  endtask
  task set_sw(input logic [11:0] v);
    @(posedge clk_in) switch_reg_out <= v;
  endtask
endmodule
`default_nettype wire

/* power_start_clear_run_control_tb.sv */
// Purpose: self-checking bench for the start clear and run control
// Assumes: power delay shortened to 20 cycles
// Notes: registers reached over AXI4-Lite; pulses counted by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module power_start_clear_run_control_tb;
  import psc_pkg::*;
  logic clk_sys_in, arst_n_in, done, awv, wv, bre, arv, rre, bad;
  logic awr, wr, bv, arr, rv, run, pdr, scl, ilc, mpr, cbl;
  logic [4:0] awa, ara;
  logic [31:0] wdat, rd, rdat;
  logic [1:0] br, rr;
  logic pge;
  logic [3:0] wst;
  logic [7:0] tp;
  logic [11:0] ug, sw;
  psc_panel_s pnl;
  int n_fail = 0;
  int cmp_count = 0;
  int n_mpr, n_scl, n_ilc;
  psc_core #(.POWER_DELAY(20)) u_psc_core (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .bad_power_in(bad),
    .panel_in(pnl), .switch_reg_in(sw), .done_in(done),
    .pulse_generation_enable_in(pge),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wdata_in(wdat), .s_axi_wstrb_in(wst), .s_axi_bready_in(bre),
    .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara), .s_axi_rready_in(rre),
    .s_axi_awready_out(awr), .s_axi_wready_out(wr), .s_axi_bvalid_out(bv),
    .s_axi_bresp_out(br), .s_axi_arready_out(arr), .s_axi_rvalid_out(rv),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .run_out(run),
    .power_delay_ready_out(pdr), .start_clear_out(scl),
    .instruction_level_clear_out(ilc), .manual_panel_request_out(mpr),
    .clock_block_out(cbl), .timing_pulse_out(tp), .utility_gates_out(ug)
  );
  psc_panel_model u_psc_panel_model (
    .clk_in(clk_sys_in), .bad_power_out(bad), .panel_out(pnl), .switch_reg_out(sw)
  );
  // ----------------------------------------
  // clock, monitor, bus tasks
  // ----------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // one-cycle pulses would be missed by polling between bus calls
  always @(posedge clk_sys_in) begin
    if (mpr) n_mpr++;
    if (scl) n_scl++;
    if (ilc) n_ilc++;
  end
  task axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    @(posedge clk_sys_in);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wdat <= d;
    bre <= 1'b1;
    ad = 0;
    dd = 0;
    while (!(ad && dd)) begin
      @(posedge clk_sys_in);
      if (awr) begin
        ad = 1;
        awv <= 1'b0;
      end
      if (wr) begin
        dd = 1;
        wv <= 1'b0;
      end
    end
    while (!bv) @(posedge clk_sys_in);
    bre <= 1'b0;
    `CHK(br, er)
  endtask
  task axr(input logic [4:0] a, input logic [1:0] er);
    @(posedge clk_sys_in);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    @(posedge clk_sys_in);
    while (!arr) @(posedge clk_sys_in);
    arv <= 1'b0;
    while (!rv) @(posedge clk_sys_in);
    rd = rdat;
    rre <= 1'b0;
    `CHK(rr, er)
  endtask
  task give_verdict();
    $display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    n_fail++;
    give_verdict();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {done, awv, wv, bre, arv, rre, awa, ara, wdat} = '0;
    {pge, wst} = 5'h1F;
    arst_n_in = 1'b0;
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    u_psc_panel_model.set_sw(12'hA5C);
    repeat (15) @(posedge clk_sys_in);
    `CHK(pdr, 1'b1)
    repeat (10) @(posedge clk_sys_in);
    `CHK({pdr, scl, run}, 3'h0)
    `CHK(ug, 12'hA5C)
    axr(REG_SWITCH, RESP_OKAY);
    `CHK(rd[11:0], 12'hA5C)
    axr(REG_STATUS, RESP_OKAY);
    `CHK(rd[8:0], 9'h001)
    axr(5'h14, RESP_SLVERR);
    `CHK(rd, WORD_ZERO)
    axw(REG_STATUS, WORD_ZERO, RESP_SLVERR);
    n_mpr = 0;
    n_scl = 0;
    for (int k = 2; k >= 0; k--) begin
      axw(REG_CTRL, 32'h0000_000C, RESP_OKAY);
      axr(REG_STATUS, RESP_OKAY);
      `CHK(rd[5:4], 2'h3)
      u_psc_panel_model.press(k);
      axr(REG_STATUS, RESP_OKAY);
      `CHK(rd[5:4], 2'h0)
    end
    `CHK(n_mpr, 3)
    `CHK(tp, 8'h00)
    `CHK(run, 1'b0)
    axw(REG_CTRL, 32'h0000_0011, RESP_OKAY);
    axr(REG_CTRL, RESP_OKAY);
    `CHK(rd[3], 1'b1)
    axw(REG_LATCH, 32'h0000_FFFF, RESP_OKAY);
    axw(REG_INSTR, 32'h0000_0FFF, RESP_OKAY);
    axr(REG_INSTR, RESP_OKAY);
    `CHK(rd[11:0], 12'hFFF)
    wst <= 4'h2;
    axw(REG_INSTR, WORD_ZERO, RESP_OKAY);
    wst <= 4'hF;
    axr(REG_INSTR, RESP_OKAY);
    `CHK(rd[11:0], 12'h0FF)
    u_psc_panel_model.press(4);
    `CHK({run, n_scl}, {1'b1, 32'd1})
    axr(REG_LATCH, RESP_OKAY);
    `CHK(rd[15:0], 16'h0000)
    axr(REG_INSTR, RESP_OKAY);
    `CHK(rd[11:0], 12'h000)
    axr(REG_CTRL, RESP_OKAY);
    `CHK(rd[3], 1'b0)
    axr(REG_STATUS, RESP_OKAY);
    `CHK(rd[0], 1'b1)
    u_psc_panel_model.press(2);
    `CHK(n_mpr, 3)
    u_psc_panel_model.press(4);
    `CHK(n_scl, 1)
    n_ilc = 0;
    @(posedge clk_sys_in) done <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    `CHK({run, n_ilc > 0}, 2'h3)
    @(posedge clk_sys_in) done <= 1'b0;
    axw(REG_CTRL, 32'h0000_0002, RESP_OKAY);
    repeat (20) @(posedge clk_sys_in);
    `CHK(run, 1'b1)
    @(posedge clk_sys_in) {done, pge} <= 2'h2;
    repeat (20) @(posedge clk_sys_in);
    `CHK(run, 1'b1)
    @(posedge clk_sys_in) pge <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    `CHK(run, 1'b0)
    @(posedge clk_sys_in) done <= 1'b0;
    u_psc_panel_model.press(4);
    `CHK(n_scl, 2)
    u_psc_panel_model.press(3);
    @(posedge clk_sys_in) done <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    `CHK(run, 1'b0)
    @(posedge clk_sys_in) done <= 1'b0;
    u_psc_panel_model.press(4);
    u_psc_panel_model.set_bad(1'b1);
    repeat (6) @(posedge clk_sys_in);
    axr(REG_STATUS, RESP_OKAY);
    `CHK({rd[7], run, cbl}, 3'h6)
    @(posedge clk_sys_in) done <= 1'b1;
    repeat (40) @(posedge clk_sys_in);
    `CHK({run, cbl}, 2'h1)
    `CHK(tp, 8'h00)
    u_psc_panel_model.set_bad(1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
